// File: core/pwm_cfg_regs.sv
// Common and per-channel PWM configuration registers with channel
// on/off sequencing. Assumes a command decoder on clk_i upstream and
// input comparators and the shared clock arriving from pins.
`timescale 1ns/1ps
`include "pwm_cfg_regs_cfg.svh"
module pwm_cfg_regs #(
    parameter int TICK_CYCLES = `CLK_HZ / 1000 * `TICK_MS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Command port
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic [1:0] cmd_page_i,
    output logic cmd_ack_o,
    output logic cmd_nack_o,
    output logic busy_fault_o,
    output logic [7:0] rd_data_o,
    // Channel control from other logic
    input wire logic [1:0] chan_on_cmd_i,
    input wire logic [15:0] off_delay_ms_i,
    input wire logic [15:0] off_ramp_ms_i,
    input wire logic [15:0] restart_ms_i,
    // Pins
    input wire logic vin_at_on_i,
    input wire logic vin_at_off_i,
    input wire logic [1:0] vout_decayed_i,
    input wire logic shared_clock_line_i,
    output logic shared_clock_line_o,
    output logic shared_clock_line_oe_o,
    output logic [1:0] channel_run_pin_o,
    output logic [1:0] channel_run_pin_oe_o,
    // Channel status and PWM setup
    output logic [1:0] chan_out_en_o,
    output logic [1:0] chan_operating_o,
    output logic [8:0] phase0_deg_o,
    output logic [8:0] phase1_deg_o,
    output logic duty_limit_high_o
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sync1_q <= 5'h01;
            sync2_q <= 5'h01;
        end
        else
        begin
            sync1_q <= {vout_decayed_i, vin_at_off_i, vin_at_on_i, shared_clock_line_i};
            sync2_q <= sync1_q;
        end
    end
    logic sclk_low, input_turn_on_threshold, input_turn_off_threshold;
    logic [1:0] decayed;
    assign sclk_low = !sync2_q[0];
    assign input_turn_on_threshold = sync2_q[1];
    assign input_turn_off_threshold = sync2_q[2];
    assign decayed = sync2_q[4:3];

    // ----------------------------------------
    // Millisecond tick
    // ----------------------------------------
    logic [17:0] div_q;
    logic tick_q;
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            div_q <= 18'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (div_q == 18'(TICK_CYCLES - 1));
            div_q <= (div_q == 18'(TICK_CYCLES - 1)) ? 18'h0 : div_q + 18'h1;
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0] common_pwm_clock_config_q;
    logic [7:0] per_channel_config_q [2];
    pwm_cfg_regs_pkg::chan_state_t state_q [2];
    logic any_running, wr_common, wr_chan, rd_hit;
    assign any_running = (state_q[0] != pwm_cfg_regs_pkg::ST_OFF) ||
        (state_q[1] != pwm_cfg_regs_pkg::ST_OFF);
    assign wr_common = cmd_valid_i && cmd_write_i && (cmd_code_i == `CMD_COMMON_CFG);
    assign wr_chan = cmd_valid_i && cmd_write_i && (cmd_code_i == `CMD_CHAN_CFG);
    assign rd_hit = (cmd_code_i == `CMD_COMMON_CFG) || (cmd_code_i == `CMD_CHAN_CFG);

    // Reserved bits are not stored, so they read back as zero
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            common_pwm_clock_config_q <= `COMMON_RST;
            per_channel_config_q[0] <= `CHAN_RST;
            per_channel_config_q[1] <= `CHAN_RST;
        end
        else
        begin
            if (wr_common && !any_running)
                common_pwm_clock_config_q <= cmd_data_i & `COMMON_MASK;
            for (int c = 0; c < 2; c++)
                if (wr_chan && cmd_page_i[c])
                    per_channel_config_q[c] <= cmd_data_i & `CHAN_MASK;
        end
    end

    // Single data byte per access; upstream frames the transaction
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cmd_ack_o <= 1'b0;
            cmd_nack_o <= 1'b0;
            busy_fault_o <= 1'b0;
            rd_data_o <= 8'h00;
        end
        else
        begin
            cmd_ack_o <= cmd_valid_i && rd_hit && !(wr_common && any_running);
            cmd_nack_o <= cmd_valid_i && (!rd_hit || (wr_common && any_running));
            busy_fault_o <= wr_common && any_running;
            if (cmd_valid_i && !cmd_write_i)
                rd_data_o <= (cmd_code_i == `CMD_COMMON_CFG) ? common_pwm_clock_config_q :
                    (cmd_code_i == `CMD_CHAN_CFG) ?
                    per_channel_config_q[cmd_page_i[0] ? 0 : 1] : 8'h00;
        end
    end

    // ----------------------------------------
    // Phase and duty decode
    // ----------------------------------------
    function automatic logic [8:0] phase_deg(input logic [2:0] code);
        case (code)
            3'h1: phase_deg = 9'd0;
            3'h2: phase_deg = 9'd60;
            3'h3: phase_deg = 9'd120;
            3'h5: phase_deg = 9'd45;
            3'h6: phase_deg = 9'd90;
            3'h7: phase_deg = 9'd135;
            default: phase_deg = 9'd0;
        endcase
    endfunction
    logic [2:0] ph;
    assign ph = common_pwm_clock_config_q[2:0];
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            phase0_deg_o <= 9'd0;
            phase1_deg_o <= 9'd0;
            duty_limit_high_o <= 1'b0;
        end
        else
        begin
            phase0_deg_o <= phase_deg(ph);
            phase1_deg_o <= phase_deg(ph) + ((ph == 3'h0) ? 9'd120 : 9'd180);
            duty_limit_high_o <= ph[2];
        end
    end

    // ----------------------------------------
    // Shared clock line
    // ----------------------------------------
    logic sclk_force_q;
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            sclk_force_q <= 1'b1;
        else if (input_turn_on_threshold)
            sclk_force_q <= 1'b0;
        else if (common_pwm_clock_config_q[`COM_SCLK_BIT] && input_turn_off_threshold)
            sclk_force_q <= 1'b1;
    end
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            shared_clock_line_o <= 1'b0;
            shared_clock_line_oe_o <= 1'b0;
        end
        else
        begin
            shared_clock_line_o <= 1'b0;
            shared_clock_line_oe_o <= sclk_force_q;
        end
    end

    // ----------------------------------------
    // Channel sequencing
    // ----------------------------------------
    function automatic logic [17:0] run_len(input logic [15:0] dly, input logic [15:0] fall,
        input logic [15:0] rst);
        logic [17:0] sum;
        sum = {2'b0, dly} + {2'b0, fall} + `RUN_EXTRA_MS;
        run_len = (sum > {2'b0, rst}) ? sum : {2'b0, rst};
    endfunction
    logic [15:0] tmr_q [2];
    logic [17:0] run_q [2];
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            for (int c = 0; c < 2; c++)
            begin
                state_q[c] <= pwm_cfg_regs_pkg::ST_OFF;
                tmr_q[c] <= 16'h0;
                run_q[c] <= 18'h0;
            end
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (tick_q && tmr_q[c] != 16'h0)
                    tmr_q[c] <= tmr_q[c] - 16'h1;
                if (tick_q && run_q[c] != 18'h0)
                    run_q[c] <= run_q[c] - 18'h1;
                case (state_q[c])
                    pwm_cfg_regs_pkg::ST_OFF:
                        // Decay gate covers re-enable from ST_OFF only; an on command during the off delay or fall with bit 3 clear skips it
                        if (chan_on_cmd_i[c] && run_q[c] == 18'h0 &&
                            (decayed[c] || per_channel_config_q[c][`CH_DECAY_BIT]))
                            state_q[c] <= pwm_cfg_regs_pkg::ST_ON;
                    pwm_cfg_regs_pkg::ST_ON:
                        if (!chan_on_cmd_i[c])
                        begin
                            state_q[c] <= pwm_cfg_regs_pkg::ST_OFF_DELAY;
                            tmr_q[c] <= off_delay_ms_i;
                            if (!per_channel_config_q[c][`CH_RUN_BIT])
                                run_q[c] <= run_len(off_delay_ms_i, off_ramp_ms_i, restart_ms_i);
                        end
                    pwm_cfg_regs_pkg::ST_OFF_DELAY, pwm_cfg_regs_pkg::ST_OFF_FALL:
                        if (chan_on_cmd_i[c] && per_channel_config_q[c][`CH_SHORT_BIT])
                        begin
                            state_q[c] <= pwm_cfg_regs_pkg::ST_MIN_OFF;
                            tmr_q[c] <= `MIN_OFF_MS;
                        end
                        else if (chan_on_cmd_i[c])
                            state_q[c] <= pwm_cfg_regs_pkg::ST_ON;
                        else if (tmr_q[c] == 16'h0)
                        begin
                            state_q[c] <= (state_q[c] == pwm_cfg_regs_pkg::ST_OFF_DELAY) ?
                                pwm_cfg_regs_pkg::ST_OFF_FALL : pwm_cfg_regs_pkg::ST_OFF;
                            tmr_q[c] <= off_ramp_ms_i;
                        end
                    pwm_cfg_regs_pkg::ST_MIN_OFF:
                        // Run pulse still pending keeps the extra delay of bit 4 clear
                        if (tmr_q[c] == 16'h0)
                            state_q[c] <= pwm_cfg_regs_pkg::ST_OFF;
                    default:
                        state_q[c] <= pwm_cfg_regs_pkg::ST_OFF;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            chan_out_en_o <= 2'b00;
            chan_operating_o <= 2'b00;
            channel_run_pin_o <= 2'b00;
            channel_run_pin_oe_o <= 2'b00;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                chan_out_en_o[c] <= (state_q[c] == pwm_cfg_regs_pkg::ST_ON ||
                    state_q[c] == pwm_cfg_regs_pkg::ST_OFF_DELAY ||
                    state_q[c] == pwm_cfg_regs_pkg::ST_OFF_FALL) &&
                    !(per_channel_config_q[c][`CH_SCLK_BIT] && sclk_low);
                chan_operating_o[c] <= state_q[c] != pwm_cfg_regs_pkg::ST_OFF;
                channel_run_pin_o[c] <= 1'b0;
                channel_run_pin_oe_o[c] <= run_q[c] != 18'h0;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence busy_write_s;
        wr_common && any_running;
    endsequence
    sequence busy_answer_s;
        cmd_nack_o && busy_fault_o && !cmd_ack_o;
    endsequence
    busy_nack_a: assert property (busy_write_s |=> busy_answer_s)
        else $error("busy write not refused");
    busy_keep_a: assert property (busy_write_s |=> $stable(common_pwm_clock_config_q))
        else $error("busy write changed register");
    sclk_release_a: assert property (input_turn_on_threshold |=> ##1 !shared_clock_line_oe_o)
        else $error("shared clock not released");
    sclk_force_a: assert property (common_pwm_clock_config_q[4] && input_turn_off_threshold && !input_turn_on_threshold
        |=> ##1 shared_clock_line_oe_o)
        else $error("shared clock not forced low");
    phase_wide_a: assert property (ph == 3'h6
        |=> phase1_deg_o == 9'd270 && duty_limit_high_o)
        else $error("wide phase code wrong");
    phase_narrow_a: assert property (ph == 3'h2
        |=> phase1_deg_o == 9'd240 && !duty_limit_high_o)
        else $error("narrow phase code wrong");
    run_pulse_a: assert property (state_q[0] == pwm_cfg_regs_pkg::ST_ON &&
        !chan_on_cmd_i[0] && !per_channel_config_q[0][4] |=> ##1 channel_run_pin_oe_o[0])
        else $error("run pin not pulsed");
    run_quiet_a: assert property (state_q[0] == pwm_cfg_regs_pkg::ST_ON &&
        run_q[0] == 18'h0 && per_channel_config_q[0][4] |=> run_q[0] == 18'h0)
        else $error("run pin pulsed with bit 4 set");
    short_cycle_a: assert property (state_q[0] == pwm_cfg_regs_pkg::ST_OFF_DELAY &&
        chan_on_cmd_i[0] && per_channel_config_q[0][3]
        |=> state_q[0] == pwm_cfg_regs_pkg::ST_MIN_OFF ##1 !chan_out_en_o[0])
        else $error("short cycle not enforced");
    follow_cmd_a: assert property (state_q[0] == pwm_cfg_regs_pkg::ST_OFF_DELAY &&
        chan_on_cmd_i[0] && !per_channel_config_q[0][3]
        |=> state_q[0] == pwm_cfg_regs_pkg::ST_ON)
        else $error("on command not followed");
    sclk_gate_a: assert property (per_channel_config_q[0][2] && sclk_low
        |=> !chan_out_en_o[0])
        else $error("output on while shared clock low");
    decay_wait_a: assert property (state_q[0] == pwm_cfg_regs_pkg::ST_OFF &&
        !per_channel_config_q[0][0] && !decayed[0] |=> state_q[0] == pwm_cfg_regs_pkg::ST_OFF)
        else $error("retry before decay");
    page_write_a: assert property (wr_chan && cmd_page_i == 2'b01
        |=> $stable(per_channel_config_q[1]))
        else $error("other channel changed");
endmodule

// File: dv/host_model.sv
// Host side of the command port: one-byte reads and writes.
// Assumes the device registers ack or nack on the same edge at which it takes a command.
`timescale 1ns/1ps
`include "pwm_cfg_regs_cfg.svh"
module host_model (
    // Clock
    input wire logic clk_i,
    // Command port toward the device
    output logic cmd_valid_o,
    output logic cmd_write_o,
    output logic [7:0] cmd_code_o,
    output logic [7:0] cmd_data_o,
    output logic [1:0] cmd_page_o,
    input wire logic cmd_ack_i,
    input wire logic cmd_nack_i,
    input wire logic busy_fault_i,
    input wire logic [7:0] rd_data_i
);
    initial
    begin
        cmd_valid_o = 1'h0;
        cmd_write_o = 1'h0;
        cmd_code_o = 8'h00;
        cmd_data_o = 8'h00;
        cmd_page_o = 2'h0;
    end

    // One command carries exactly one data byte
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] data,
                        input logic [1:0] page, output logic [7:0] rd, output logic [2:0] resp);
        logic [7:0] wdata;
        wdata = (code == `CMD_COMMON_CFG) ? (data & 8'h3f) : (data & 8'hfd);
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'h1;
        cmd_write_o = wr;
        cmd_code_o = code;
        cmd_data_o = wdata;
        cmd_page_o = page;
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'h0;
        // Idle lines toggle so a stale byte is never mistaken for a fresh one
        cmd_code_o = ~code;
        cmd_data_o = ~wdata;
        resp = {busy_fault_i, cmd_nack_i, cmd_ack_i};
        rd = rd_data_i;
    endtask
endmodule

// File: dv/tb.sv
// Self-checking bench for the PWM configuration register block.
// Assumes host_model drives the command port; pins and channel inputs are driven here.
`timescale 1ns/1ps
`include "pwm_cfg_regs_cfg.svh"
module tb;
    typedef struct packed {
        logic [7:0] data;
        logic [8:0] ph0;
        logic [8:0] ph1;
        logic duty;
    } row_t;
    localparam int TICK = 4;
    logic clk_i, sys_rst_i, valid, write, ack, nack, busy, input_turn_on_threshold, input_turn_off_threshold, ext_low;
    logic sclk_o, sclk_oe, sclk_w, duty;
    logic [7:0] code, data, rd, rd_data_w;
    logic [1:0] page, on_cmd, decayed, run_o, run_oe, out_en, oper;
    logic [15:0] dly, ramp, rst_ms;
    logic [8:0] ph0, ph1;
    logic [2:0] resp;
    int err_count, tests_run, cycles, n, e;
    row_t rows [8];

    initial
    begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Open-drain shared clock with pull-up; the bench may also pull it low
    assign sclk_w = sclk_oe ? sclk_o : !ext_low;

    pwm_cfg_regs #(.TICK_CYCLES(TICK)) pwm_cfg_regs_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(valid), .cmd_write_i(write),
        .cmd_code_i(code), .cmd_data_i(data), .cmd_page_i(page), .cmd_ack_o(ack),
        .cmd_nack_o(nack), .busy_fault_o(busy), .rd_data_o(rd_data_w),
        .chan_on_cmd_i(on_cmd), .off_delay_ms_i(dly), .off_ramp_ms_i(ramp),
        .restart_ms_i(rst_ms), .vin_at_on_i(input_turn_on_threshold), .vin_at_off_i(input_turn_off_threshold),
        .vout_decayed_i(decayed), .shared_clock_line_i(sclk_w), .shared_clock_line_o(sclk_o),
        .shared_clock_line_oe_o(sclk_oe), .channel_run_pin_o(run_o),
        .channel_run_pin_oe_o(run_oe), .chan_out_en_o(out_en), .chan_operating_o(oper),
        .phase0_deg_o(ph0), .phase1_deg_o(ph1), .duty_limit_high_o(duty));

    host_model host_model_i (
        .clk_i(clk_i), .cmd_valid_o(valid), .cmd_write_o(write), .cmd_code_o(code),
        .cmd_data_o(data), .cmd_page_o(page), .cmd_ack_i(ack), .cmd_nack_i(nack),
        .busy_fault_i(busy), .rd_data_i(rd_data_w));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    function automatic logic probe(input int sel);
        return (sel == 0) ? run_oe[0] : !out_en[0];
    endfunction

    // Waits a bounded time for the condition, then counts how long it holds
    task automatic span(input int sel, input int lim, output int len);
        len = 0;
        repeat (lim)
            if (probe(sel) !== 1'h1)
                cyc(1);
        while (probe(sel) === 1'h1 && len < 2000)
        begin
            cyc(1);
            len++;
        end
    endtask

    task automatic quiet(input int sel, output int len);
        len = 0;
        repeat (200)
        begin
            cyc(1);
            if (probe(sel) !== 1'h0)
                len++;
        end
    endtask

    task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic [1:0] p);
        host_model_i.xfer(1'h1, c, d, p, rd, resp);
    endtask

    task automatic final_report();
        if (err_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_rst_i = 1'h1;
        on_cmd = 2'h0;
        decayed = 2'h3;
        input_turn_on_threshold = 1'h0;
        input_turn_off_threshold = 1'h0;
        ext_low = 1'h0;
        dly = 16'h0002;
        ramp = 16'h0002;
        rst_ms = 16'h0000;
        rows = '{'{8'h10, 9'h000, 9'h078, 1'h0}, '{8'h11, 9'h000, 9'h0b4, 1'h0},
                 '{8'h12, 9'h03c, 9'h0f0, 1'h0}, '{8'h13, 9'h078, 9'h12c, 1'h0},
                 '{8'h14, 9'h000, 9'h0b4, 1'h1}, '{8'h15, 9'h02d, 9'h0e1, 1'h1},
                 '{8'h16, 9'h05a, 9'h10e, 1'h1}, '{8'h17, 9'h087, 9'h13b, 1'h1}};
        repeat (10) @(posedge clk_i);
        #1;
        sys_rst_i = 1'h0;
        cyc(4);
        chk(sclk_oe, 1'h1);
        input_turn_on_threshold = 1'h1;
        cyc(5);
        chk(sclk_oe, 1'h0);
        host_model_i.xfer(1'h0, `CMD_COMMON_CFG, 8'h00, 2'h1, rd, resp);
        chk({resp, rd}, {3'h1, 8'h14});
        for (int p = 1; p < 3; p++)
        begin
            host_model_i.xfer(1'h0, `CMD_CHAN_CFG, 8'h00, p[1:0], rd, resp);
            chk(rd, 8'h1d);
        end
        host_model_i.xfer(1'h0, 8'h00, 8'h00, 2'h1, rd, resp);
        chk({resp, rd}, {3'h2, 8'h00});
        foreach (rows[i])
        begin
            wr(`CMD_COMMON_CFG, rows[i].data, 2'h0);
            chk(resp, 3'h1);
            cyc(1);
            chk({ph0, ph1, duty}, {rows[i].ph0, rows[i].ph1, rows[i].duty});
            host_model_i.xfer(1'h0, `CMD_COMMON_CFG, 8'h00, 2'h0, rd, resp);
            chk(rd, rows[i].data);
        end
        // Shared clock forcing with common bit 4 set, then cleared
        input_turn_on_threshold = 1'h0;
        input_turn_off_threshold = 1'h1;
        cyc(5);
        chk(sclk_oe, 1'h1);
        input_turn_off_threshold = 1'h0;
        cyc(5);
        chk(sclk_oe, 1'h1);
        input_turn_on_threshold = 1'h1;
        cyc(5);
        chk(sclk_oe, 1'h0);
        wr(`CMD_COMMON_CFG, 8'hc7, 2'h0);
        input_turn_on_threshold = 1'h0;
        input_turn_off_threshold = 1'h1;
        cyc(5);
        chk(sclk_oe, 1'h0);
        input_turn_on_threshold = 1'h1;
        input_turn_off_threshold = 1'h0;
        wr(`CMD_CHAN_CFG, 8'h0f, 2'h2);
        host_model_i.xfer(1'h0, `CMD_CHAN_CFG, 8'h00, 2'h1, rd, resp);
        chk(rd, 8'h1d);
        host_model_i.xfer(1'h0, `CMD_CHAN_CFG, 8'h00, 2'h2, rd, resp);
        chk(rd, 8'h0d);
        // Common write refused while a channel runs
        on_cmd = 2'h1;
        cyc(5);
        chk({oper[0], out_en[0]}, 2'h3);
        wr(`CMD_COMMON_CFG, 8'h04, 2'h0);
        chk(resp, 3'h6);
        host_model_i.xfer(1'h0, `CMD_COMMON_CFG, 8'h00, 2'h0, rd, resp);
        chk(rd, 8'h07);
        ext_low = 1'h1;
        cyc(5);
        chk(out_en[0], 1'h0);
        ext_low = 1'h0;
        cyc(5);
        chk(out_en[0], 1'h1);
        wr(`CMD_CHAN_CFG, 8'h19, 2'h1);
        ext_low = 1'h1;
        cyc(5);
        chk(out_en[0], 1'h1);
        ext_low = 1'h0;
        on_cmd = 2'h0;
        quiet(0, n);
        chk({n[7:0], oper[0]}, 9'h000);
        // Short cycle: on during the off delay
        dly = 16'h0014;
        on_cmd = 2'h1;
        cyc(5);
        on_cmd = 2'h0;
        cyc(10);
        on_cmd = 2'h1;
        span(1, 5, n);
        chk(n >= 119 * TICK && n <= 120 * TICK + 12, 1'h1);
        wr(`CMD_CHAN_CFG, 8'h11, 2'h1);
        cyc(5);
        on_cmd = 2'h0;
        cyc(10);
        on_cmd = 2'h1;
        quiet(1, n);
        chk(n, 0);
        dly = 16'h0002;
        wr(`CMD_CHAN_CFG, 8'h01, 2'h1);
        for (int k = 0; k < 2; k++)
        begin
            rst_ms = (k == 0) ? 16'h0000 : 16'h00c8;
            e = (k == 0) ? 140 : 200;
            on_cmd = 2'h0;
            span(0, 10, n);
            chk(n >= (e - 1) * TICK && n <= e * TICK + 4, 1'h1);
            chk({sclk_o, run_o}, 3'h0);
            on_cmd = 2'h1;
            cyc(20);
            chk(out_en[0], 1'h1);
        end
        wr(`CMD_CHAN_CFG, 8'h10, 2'h1);
        decayed = 2'h0;
        on_cmd = 2'h0;
        cyc(100);
        on_cmd = 2'h1;
        cyc(100);
        chk(out_en[0], 1'h0);
        decayed = 2'h1;
        cyc(10);
        chk(out_en[0], 1'h1);
        chk({oper[1], out_en[1], run_oe[1]}, 3'h0);
        final_report();
    end
endmodule

// File: inc/pwm_cfg_regs_cfg.svh
// Command codes, field positions, reset values and timing for the
// PWM configuration registers. Assumes a 200 MHz system clock.
// What this block does
// - Common register write while a channel runs is NACKed, dropped, busy fault raised.
// - Common bit 4 clear: shared clock released for good once input reaches on level.
// - Common bit 4 set: shared clock held low from off level until on level.
// - Phase codes 1xx give 0/45/90/135 degrees plus 180, duty limit 87.5%.
// - Phase codes 0xx give 0/120, 0/180, 60/240, 120/300, duty limit 83.3%.
// - Channel bit 4 clear: turn-off pulses run pin low for delay+fall+136ms or restart.
// - Channel bit 4 set: run pin never pulsed low on turn-off.
// - Channel bit 3 clear: on and off commands followed exactly.
// - Channel bit 3 set: on during turn-off disables at once, 120ms minimum off.
// - Channel bit 2 set: output disabled while shared clock held low.
// - Channel bit 0 clear: retry from ST_OFF waits for output decay to 12.5 percent.
// - Common command carries exactly one data byte per transaction.
// - Common register at code 0xF5, non-paged, reset value 0x14.
`ifndef PWM_CFG_REGS_CFG_SVH
`define PWM_CFG_REGS_CFG_SVH
`define CMD_COMMON_CFG 8'hf5
`define CMD_CHAN_CFG 8'hd0
`define COMMON_RST 8'h14
`define CHAN_RST 8'h1d
`define COMMON_MASK 8'h17
`define CHAN_MASK 8'h1d
`define COM_SCLK_BIT 4
`define CH_RUN_BIT 4
`define CH_SHORT_BIT 3
`define CH_SCLK_BIT 2
`define CH_DECAY_BIT 0
`define CLK_HZ 200000000
`define TICK_MS 1
`define RUN_EXTRA_MS 18'd136
`define MIN_OFF_MS 16'd120
`endif

// File: inc/pwm_cfg_regs_pkg.sv
// Types shared by the PWM configuration register block.
// Assumes the constants header is included alongside.
package pwm_cfg_regs_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_ON,
        ST_OFF_DELAY,
        ST_OFF_FALL,
        ST_MIN_OFF
    } chan_state_t;
endpackage
